// ==== rps_far_side.sv ====
// far-side model: remappable pads and peripheral output units around the fabric
`default_nettype none
module rps_far_side
    import rps_pkg::*;
(
    // clock
    input wire logic mclk,
    // levels chosen by the bench
    input wire logic [NUM_PINS-1:0] padDrive,
    input wire logic [NUM_FUNC-1:0] funcDrive,
    // fabric side
    input wire logic [NUM_PINS-1:0] pinOut,
    input wire logic [NUM_PINS-1:0] pinRemapEn,
    output logic [NUM_PINS-1:0] pinIn,
    output logic [NUM_FUNC-1:0] periphOut
);
    timeunit 1ns;
    timeprecision 1ns;
    // a remapped pad is driven by the fabric, so the input path sees that level
    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            pinIn[p] = pinRemapEn[p] ? pinOut[p] : padDrive[p];
        end
    end
    // peripheral outputs leave flops, as real units launch them
    always_ff @(posedge mclk) begin
        periphOut <= funcDrive;
    end
endmodule
`default_nettype wire

// ==== rps_pin_remap_fabric.sv ====
// pin remap fabric: selector registers, write lock with key sequence, routing
//
// Notes on behaviour
// R1: each peripheral input has a 5-bit selector naming the pin that feeds it
// R2: each remappable pin has a selector naming the peripheral output it carries
// R3: output codes 1,2,5,6,9,10,12,13,14-17,18-21 select the listed functions
// R4: output selector value zero leaves the pin disconnected from all functions
// R5: reset loads input selectors with all ones, output selectors with zeros
// R6: parking on pin 31 is legal even when that pin does not exist
// R7: one pin may feed many inputs; one output may drive many pins
// R8: beyond contention blocking, no restriction is placed on selector values
// R9: selector writes while locked complete normally but change nothing
// R10: lock bit is bit 0 of the control register; set blocks writes
// R11: lock changes only after keys 55h then AAh, then one control write
// R12: lock holds its value; one unlock allows any number of writes
// R13: shadow copies are compared continuously; any difference raises mismatch reset
// R14: with the one-way fuse, a set lock cannot be cleared until reset
// R15: fuse set (unprogrammed) gives one session; cleared gives unlimited sessions
// R16: reset clears the lock so selectors are writable at once
// R17: mapping never touches pin direction nor enables the peripheral
// R18: analog pins keep analog mode; remapped functions are held off them
// R19: software should relock after setup and unlock with interrupts off
// R20: software should park unused inputs and null unused pin outputs
// R21: an active remapped function overrides other digital pin functions
// R22: key, key and lock writes must be consecutive; other writes abort, a first key restarts the sequence
`default_nettype none
module rps_pin_remap_fabric
    import rps_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register bus
    input wire rps_apb_req_t apbReq,
    output rps_apb_rsp_t apbRsp,
    // configuration fuse, high when unprogrammed
    input wire logic oneShotLockFuse,
    // pin side
    input wire logic [NUM_PINS-1:0] pinIn,
    input wire logic [NUM_PINS-1:0] pinAnalog,
    output logic [NUM_PINS-1:0] pinOut,
    output logic [NUM_PINS-1:0] pinRemapEn,
    // peripheral side
    input wire logic [NUM_FUNC-1:0] periphOut,
    output logic [NUM_IN-1:0] periphIn,
    // safety
    output logic cfgMismatchReset
);

    rps_state_t st_reg;
    rps_state_t st_next;

    logic xferDone;
    logic wrDone;
    logic [ADDR_W-1:0] offs;
    logic [SEL_W-1:0] regIdx;
    logic inHit;
    logic outHit;
    logic ctrlHit;
    logic keyHit;
    logic statHit;

    // pin 31 and other absent pins read low
    function automatic logic pickPin(input logic [NUM_PINS-1:0] pins,
                                     input logic [SEL_W-1:0] sel);
        logic v;
        v = 1'b0;
        if (sel < SEL_W'(NUM_PINS)) begin
            v = pins[sel];
        end
        return v;
    endfunction

    function automatic logic isFunc(input logic [SEL_W-1:0] code);
        logic v;
        v = (code == FN_COMPARATOR1) || (code == FN_COMPARATOR2) ||
            (code == FN_SERIAL2_TX_CLK) || (code == FN_SERIAL2_SYNC) ||
            (code == FN_SPI2_DATA_OUT) || (code == FN_SPI2_CLOCK_OUT) ||
            (code == FN_SPI_DMA_SELECT) || (code == FN_WAKE_EVENT) ||
            ((code >= FN_PWM1_FIRST) && (code <= FN_PWM2_LAST));
        return v;
    endfunction

    assign offs = apbReq.paddr;
    assign regIdx = offs[IDX_MSB:IDX_LSB];
    assign xferDone = apbReq.psel && apbReq.penable && st_reg.rsp.pready;
    assign wrDone = xferDone && apbReq.pwrite;
    assign inHit = ((offs & REGION_MASK) == ADDR_IN_BASE) && (offs[1:0] == 2'b00) &&
                   (regIdx < SEL_W'(NUM_IN));
    assign outHit = ((offs & REGION_MASK) == ADDR_OUT_BASE) && (offs[1:0] == 2'b00) &&
                    (regIdx < SEL_W'(NUM_PINS));
    assign ctrlHit = (offs == ADDR_CTRL);
    assign keyHit = (offs == ADDR_KEY);
    assign statHit = (offs == ADDR_STAT);

    always_comb begin
        logic [DATA_W-1:0] rd;
        rd = '0;
        st_next = st_reg;

        // bus: one wait state, answer registered
        st_next.rsp.pready = 1'b0;
        st_next.rsp.pslverr = 1'b0;
        if (apbReq.psel && apbReq.penable && !st_reg.rsp.pready) begin
            if (inHit) begin
                rd[SEL_W-1:0] = st_reg.inSel[regIdx];
            end else if (outHit) begin
                rd[SEL_W-1:0] = st_reg.outSel[regIdx];
            end else if (ctrlHit) begin
                rd[LOCK_BIT] = st_reg.lock;
            end else if (statHit) begin
                rd[STAT_ARMED_BIT] = (st_reg.ulState == UL_ARMED);
                rd[STAT_FUSE_BIT] = oneShotLockFuse;
            end
            st_next.rsp.pready = 1'b1;
            st_next.rsp.pslverr = !(inHit || outHit || ctrlHit || keyHit || statHit);
            st_next.rsp.prdata = apbReq.pwrite ? '0 : rd;
        end

        if (wrDone) begin
            // locked selector writes are accepted silently
            if (inHit && !st_reg.lock) begin // R1 R9 R10
                st_next.inSel[regIdx] = apbReq.pwdata[SEL_W-1:0];
                st_next.inShadow[regIdx] = apbReq.pwdata[SEL_W-1:0];
            end
            if (outHit && !st_reg.lock) begin // R2 R8 R9 R10
                st_next.outSel[regIdx] = apbReq.pwdata[SEL_W-1:0];
                st_next.outShadow[regIdx] = apbReq.pwdata[SEL_W-1:0];
            end
            // any write other than the next expected step or a first key aborts; a first key restarts at UL_KEY1
            unique case (st_reg.ulState)
                UL_IDLE: begin
                    if (keyHit && apbReq.pwdata[7:0] == KEY_FIRST) begin // R11
                        st_next.ulState = UL_KEY1;
                    end
                end
                UL_KEY1: begin
                    if (keyHit && apbReq.pwdata[7:0] == KEY_SECOND) begin // R11
                        st_next.ulState = UL_ARMED;
                    end else if (keyHit && apbReq.pwdata[7:0] == KEY_FIRST) begin
                        st_next.ulState = UL_KEY1;
                    end else begin
                        st_next.ulState = UL_IDLE; // R22
                    end
                end
                UL_ARMED: begin
                    if (ctrlHit) begin
                        // fuse makes a set lock sticky until reset
                        if (!(oneShotLockFuse && st_reg.lock)) begin // R14 R15
                            st_next.lock = apbReq.pwdata[LOCK_BIT]; // R11 R12
                        end
                        st_next.ulState = UL_IDLE;
                    end else if (keyHit && apbReq.pwdata[7:0] == KEY_FIRST) begin
                        st_next.ulState = UL_KEY1;
                    end else begin
                        st_next.ulState = UL_IDLE; // R22
                    end
                end
                default: begin
                    st_next.ulState = UL_IDLE;
                end
            endcase
        end

        // routing; one selector per input and per pin rules out contention
        for (int i = 0; i < NUM_IN; i++) begin
            st_next.periphIn[i] = pickPin(pinIn, st_reg.inSel[i]); // R1 R6 R7
        end
        for (int p = 0; p < NUM_PINS; p++) begin
            // enable flags priority to the pad mux; direction is left alone
            st_next.pinRemapEn[p] = isFunc(st_reg.outSel[p]) && !pinAnalog[p]; // R4 R17 R18 R21
            st_next.pinOut[p] = st_next.pinRemapEn[p] &&
                                periphOut[st_reg.outSel[p]]; // R3 R7
        end

        // live and shadow only diverge through upset, never through writes
        st_next.mismatchRst = (st_reg.inSel != st_reg.inShadow) ||
                              (st_reg.outSel != st_reg.outShadow); // R13
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_reg <= '0;
            for (int i = 0; i < NUM_IN; i++) begin
                st_reg.inSel[i] <= SEL_IN_RST; // R5 R6
                st_reg.inShadow[i] <= SEL_IN_RST;
            end
            for (int p = 0; p < NUM_PINS; p++) begin
                st_reg.outSel[p] <= OUT_NULL; // R5
                st_reg.outShadow[p] <= OUT_NULL;
            end
            st_reg.lock <= 1'b0; // R16
            st_reg.ulState <= UL_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign apbRsp = st_reg.rsp;
    assign pinOut = st_reg.pinOut;
    assign pinRemapEn = st_reg.pinRemapEn;
    assign periphIn = st_reg.periphIn;
    assign cfgMismatchReset = st_reg.mismatchRst;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    AST_RESET_STATE: // R5
    assert property ($past(reset_n) == 1'b0 |->
                     st_reg.lock == 1'b0 && st_reg.ulState == UL_IDLE &&
                     st_reg.inSel[IN_EXT_IRQ_ONE] == SEL_IN_RST &&
                     st_reg.inSel[IN_PWM_FAULT] == SEL_IN_RST &&
                     st_reg.outSel[0] == OUT_NULL)
        else $error("selectors or lock wrong after reset");

    AST_LOCKED_WRITE_HELD: // R9
    assert property (wrDone && st_reg.lock && (inHit || outHit) |=>
                     $stable(st_reg.inSel) && $stable(st_reg.outSel))
        else $error("selector changed while locked");

    AST_UNLOCKED_WRITE_TAKES: // R1
    assert property (wrDone && !st_reg.lock && inHit |=>
                     st_reg.inSel[$past(regIdx)] == $past(apbReq.pwdata[SEL_W-1:0]))
        else $error("unlocked input selector write lost");

    AST_LOCK_NEEDS_KEYS: // R11
    assert property ($changed(st_reg.lock) |->
                     $past(st_reg.ulState) == UL_ARMED && $past(wrDone) && $past(ctrlHit))
        else $error("lock changed without key sequence");

    AST_FIRST_KEY: // R11
    assert property (wrDone && keyHit && apbReq.pwdata[7:0] == KEY_FIRST |=>
                     st_reg.ulState == UL_KEY1)
        else $error("first key did not start the unlock sequence");

    AST_KEYS_ARM: // R11
    assert property (wrDone && keyHit && apbReq.pwdata[7:0] == KEY_SECOND &&
                     st_reg.ulState == UL_KEY1 |=> st_reg.ulState == UL_ARMED)
        else $error("key pair did not arm the lock write");

    AST_ABORT_ON_OTHER: // R22
    assert property (wrDone && st_reg.ulState == UL_KEY1 && !keyHit |=>
                     st_reg.ulState == UL_IDLE)
        else $error("intervening write did not abort unlock");

    AST_ONE_WAY_LOCK: // R14
    assert property (oneShotLockFuse && st_reg.lock |=> st_reg.lock)
        else $error("lock cleared despite one-way fuse");

    AST_LOCK_PERSISTS: // R12
    assert property (!(wrDone && ctrlHit && st_reg.ulState == UL_ARMED) |=>
                     $stable(st_reg.lock))
        else $error("lock changed on its own");

    AST_MISMATCH_RESET: // R13
    assert property (st_reg.inSel != st_reg.inShadow || st_reg.outSel != st_reg.outShadow
                     |=> cfgMismatchReset)
        else $error("shadow mismatch not reported");

    AST_NO_FALSE_MISMATCH: // R13
    assert property (st_reg.inSel == st_reg.inShadow && st_reg.outSel == st_reg.outShadow
                     |=> !cfgMismatchReset)
        else $error("mismatch reported while shadows agree");

    AST_BUS_ANSWER:
    assert property (apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready)
        else $error("bus answer late");

    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin_ast
        AST_NULL_DISCONNECTS: // R4
        assert property (st_reg.outSel[p] == OUT_NULL |=>
                         !pinRemapEn[p] && !pinOut[p])
            else $error("null code left pin connected");

        AST_ANALOG_WINS: // R18
        assert property (pinAnalog[p] |=> !pinRemapEn[p])
            else $error("remap enabled on analog pin");

        AST_OUT_FOLLOWS: // R3
        assert property (isFunc(st_reg.outSel[p]) && !pinAnalog[p] |=>
                         pinRemapEn[p] && pinOut[p] == $past(periphOut[st_reg.outSel[p]]))
            else $error("pin output does not follow selected function");
    end

    for (genvar i = 0; i < NUM_IN; i++) begin : g_in_ast
        AST_IN_FOLLOWS: // R1
        assert property (1'b1 |=> periphIn[i] == $past(pickPin(pinIn, st_reg.inSel[i])))
            else $error("peripheral input does not follow selected pin");
    end

endmodule
`default_nettype wire

// ==== rps_pin_remap_fabric_tb.sv ====
// self-checking bench for the pin remap fabric
`default_nettype none
module rps_pin_remap_fabric_tb
    import rps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] CODES [16] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h09, 5'h0a, 5'h0c,
        5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    rps_apb_req_t apbReq = '0;
    rps_apb_rsp_t apbRsp;
    logic oneShotLockFuse = 1'b0;
    logic [NUM_PINS-1:0] pinAnalog = '0;
    logic [NUM_PINS-1:0] padDrive = 22'h2a_5c3b;
    logic [NUM_FUNC-1:0] funcDrive = 32'h5a3c_96e1;
    logic [NUM_PINS-1:0] pinIn;
    logic [NUM_PINS-1:0] pinOut;
    logic [NUM_PINS-1:0] pinRemapEn;
    logic [NUM_FUNC-1:0] periphOut;
    logic [NUM_IN-1:0] periphIn;
    logic cfgMismatchReset;
    int errors = 0;
    int testsRun = 0;

    always #20 mclk = ~mclk;

    rps_pin_remap_fabric dut_u (.mclk(mclk), .reset_n(reset_n), .apbReq(apbReq),
        .apbRsp(apbRsp), .oneShotLockFuse(oneShotLockFuse), .pinIn(pinIn),
        .pinAnalog(pinAnalog), .pinOut(pinOut), .pinRemapEn(pinRemapEn),
        .periphOut(periphOut), .periphIn(periphIn), .cfgMismatchReset(cfgMismatchReset));

    rps_far_side far_u (.mclk(mclk), .padDrive(padDrive), .funcDrive(funcDrive),
        .pinOut(pinOut), .pinRemapEn(pinRemapEn), .pinIn(pinIn), .periphOut(periphOut));

    task automatic wrap_up();
        if (errors == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask

    function automatic logic [11:0] inA(input int i);
        return ADDR_IN_BASE + 12'(4 * i);
    endfunction

    function automatic logic [11:0] outA(input int p);
        return ADDR_OUT_BASE + 12'(4 * p);
    endfunction

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 50);
        r = apbRsp.prdata;
        e = apbRsp.pslverr;
        apbReq <= '0;
        if (n >= 50) check("pready wait", 32'h0000_0001, 32'h0000_0000);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check($sformatf("write error at %h", a), 32'h0000_0000, 32'(e));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check($sformatf("read at %h", a), exp, r);
        check($sformatf("read error at %h", a), 32'h0000_0000, 32'(e));
    endtask

    task automatic unlock(input logic [31:0] ctrl);
        wr(ADDR_KEY, 32'(KEY_FIRST));
        wr(ADDR_KEY, 32'(KEY_SECOND));
        wr(ADDR_CTRL, ctrl);
    endtask

    task automatic do_reset();
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic t_reset();
        for (int i = 0; i < NUM_IN; i++) rd(inA(i), 32'(SEL_IN_RST));
        for (int p = 0; p < NUM_PINS; p++) rd(outA(p), 32'(OUT_NULL));
        rd(ADDR_CTRL, 32'h0000_0000);
        check("pinRemapEn", 32'h0000_0000, 32'(pinRemapEn));
        check("periphIn parked", 32'h0000_0000, 32'(periphIn));
        check("cfgMismatchReset", 32'h0000_0000, 32'(cfgMismatchReset));
    endtask

    task automatic t_inputs();
        for (int i = 0; i < NUM_IN; i++) wr(inA(i), 32'(i + 3));
        repeat (2) begin
            @(posedge mclk);
            padDrive <= ~padDrive;
            repeat (3) @(posedge mclk);
            for (int i = 0; i < NUM_IN; i++) begin
                check("periphIn", 32'(padDrive[i + 3]), 32'(periphIn[i]));
            end
        end
        for (int i = 0; i < NUM_IN; i++) wr(inA(i), 32'h0000_0005);
        repeat (3) @(posedge mclk);
        check("periphIn fanout", 32'({NUM_IN{padDrive[5]}}), 32'(periphIn));
    endtask

    task automatic t_outputs();
        for (int p = 0; p < 16; p++) wr(outA(p), 32'(CODES[p]));
        wr(outA(16), 32'(FN_WAKE_EVENT));
        wr(outA(17), 32'h0000_0003);
        wr(outA(18), 32'(OUT_NULL));
        @(posedge mclk);
        pinAnalog <= 22'h08_0000;
        wr(outA(19), 32'(FN_COMPARATOR1));
        rd(outA(17), 32'h0000_0003);
        repeat (2) begin
            @(posedge mclk);
            funcDrive <= ~funcDrive;
            repeat (4) @(posedge mclk);
            for (int p = 0; p < 16; p++) begin
                check("pinOut", 32'(funcDrive[CODES[p]]), 32'(pinOut[p]));
            end
            check("pinOut fanout", 32'(funcDrive[FN_WAKE_EVENT]), 32'(pinOut[16]));
            check("pinOut idle", 32'h0000_0000, 32'(pinOut[21:17]));
        end
        check("pinRemapEn", 32'h0001_ffff, 32'(pinRemapEn));
        check("cfgMismatchReset", 32'h0000_0000, 32'(cfgMismatchReset));
    endtask

    task automatic t_lock();
        unlock(32'h0000_0001);
        rd(ADDR_CTRL, 32'h0000_0001);
        wr(inA(0), 32'h0000_0007);
        rd(inA(0), 32'(SEL_IN_RST));
        wr(ADDR_KEY, 32'(KEY_FIRST));
        wr(outA(0), 32'h0000_0001);
        wr(ADDR_KEY, 32'(KEY_SECOND));
        wr(ADDR_CTRL, 32'h0000_0000);
        rd(ADDR_CTRL, 32'h0000_0001);
        rd(outA(0), 32'h0000_0000);
        wr(ADDR_KEY, 32'(KEY_FIRST));
        wr(ADDR_KEY, 32'(KEY_SECOND));
        rd(ADDR_STAT, 32'h0000_0001);
        unlock(32'h0000_0000);
        wr(inA(0), 32'h0000_0002);
        wr(inA(1), 32'h0000_0004);
        rd(inA(0), 32'h0000_0002);
        rd(inA(1), 32'h0000_0004);
        wr(ADDR_CTRL, 32'h0000_0001);
        rd(ADDR_CTRL, 32'h0000_0000);
    endtask

    task automatic t_fuse();
        @(posedge mclk);
        oneShotLockFuse <= 1'b1;
        unlock(32'h0000_0001);
        rd(ADDR_CTRL, 32'h0000_0001);
        rd(ADDR_STAT, 32'h0000_0002);
        unlock(32'h0000_0000);
        rd(ADDR_CTRL, 32'h0000_0001);
        wr(inA(2), 32'h0000_0009);
        rd(inA(2), 32'(SEL_IN_RST));
        do_reset();
        rd(ADDR_CTRL, 32'h0000_0000);
        wr(inA(2), 32'h0000_0009);
        rd(inA(2), 32'h0000_0009);
    endtask

    // unmapped and misaligned places answer with an error and read zero
    task automatic t_unmapped();
        logic [31:0] r;
        logic e;
        apb(1'b1, 12'h200, 32'h0000_0001, r, e);
        check("unmapped write error", 32'h0000_0001, 32'(e));
        apb(1'b0, 12'h102, 32'h0000_0000, r, e);
        check("misaligned read error", 32'h0000_0001, 32'(e));
        check("misaligned read data", 32'h0000_0000, r);
    endtask

    initial begin
        do_reset();
        t_reset();
        t_inputs();
        t_outputs();
        do_reset();
        t_reset();
        t_lock();
        do_reset();
        t_fuse();
        t_unmapped();
        wrap_up();
    end

    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== rps_pkg.sv ====
// constants, types and register map of the remappable pin select fabric
`default_nettype none
package rps_pkg;
    // fabric dimensions
    localparam int NUM_IN = 15;
    localparam int NUM_PINS = 22;
    localparam int SEL_W = 5;
    localparam int NUM_FUNC = 32;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // selector values
    localparam logic [4:0] SEL_IN_RST = 5'h1f;
    localparam logic [4:0] OUT_NULL = 5'h00;

    // peripheral input indices
    localparam int IN_EXT_IRQ_ONE = 0;
    localparam int IN_EXT_IRQ_TWO = 1;
    localparam int IN_EXT_IRQ_THREE = 2;
    localparam int IN_TIMER0_CLOCK = 3;
    localparam int IN_TIMER3_CLOCK = 4;
    localparam int IN_CAPTURE1 = 5;
    localparam int IN_CAPTURE2 = 6;
    localparam int IN_TIMER1_GATE = 7;
    localparam int IN_TIMER3_GATE = 8;
    localparam int IN_SERIAL2_RECEIVE = 9;
    localparam int IN_SERIAL2_CLOCK = 10;
    localparam int IN_SPI2_DATA = 11;
    localparam int IN_SPI2_CLOCK = 12;
    localparam int IN_SPI2_SELECT = 13;
    localparam int IN_PWM_FAULT = 14;

    // peripheral output function codes
    localparam logic [4:0] FN_COMPARATOR1 = 5'h01;
    localparam logic [4:0] FN_COMPARATOR2 = 5'h02;
    localparam logic [4:0] FN_SERIAL2_TX_CLK = 5'h05;
    localparam logic [4:0] FN_SERIAL2_SYNC = 5'h06;
    localparam logic [4:0] FN_SPI2_DATA_OUT = 5'h09;
    localparam logic [4:0] FN_SPI2_CLOCK_OUT = 5'h0a;
    localparam logic [4:0] FN_SPI_DMA_SELECT = 5'h0c;
    localparam logic [4:0] FN_WAKE_EVENT = 5'h0d;
    localparam logic [4:0] FN_PWM1_FIRST = 5'h0e;
    localparam logic [4:0] FN_PWM2_LAST = 5'h15;

    // register map (byte addresses)
    localparam logic [11:0] ADDR_IN_BASE = 12'h000;
    localparam logic [11:0] ADDR_OUT_BASE = 12'h080;
    localparam logic [11:0] REGION_MASK = 12'hf80;
    localparam logic [11:0] ADDR_CTRL = 12'h100;
    localparam logic [11:0] ADDR_KEY = 12'h104;
    localparam logic [11:0] ADDR_STAT = 12'h108;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 6;
    localparam int LOCK_BIT = 0;
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_FUSE_BIT = 1;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    typedef enum logic [2:0] {
        UL_IDLE = 3'b001,
        UL_KEY1 = 3'b010,
        UL_ARMED = 3'b100
    } rps_unlock_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } rps_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } rps_apb_rsp_t;

    typedef struct packed {
        logic [NUM_IN-1:0][SEL_W-1:0] inSel;
        logic [NUM_PINS-1:0][SEL_W-1:0] outSel;
        logic [NUM_IN-1:0][SEL_W-1:0] inShadow;
        logic [NUM_PINS-1:0][SEL_W-1:0] outShadow;
        logic lock;
        rps_unlock_t ulState;
        rps_apb_rsp_t rsp;
        logic [NUM_IN-1:0] periphIn;
        logic [NUM_PINS-1:0] pinOut;
        logic [NUM_PINS-1:0] pinRemapEn;
        logic mismatchRst;
    } rps_state_t;
endpackage
`default_nettype wire
